// ===== logic/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // Summary of operation
  // - timer enable bits 5..0 pass (1) or block (0) timer 5..0 requests
  // - misc enable gates serial unit 2, interval timer, watchdog, watch timer, memory, converter
  // - serial/ext enable gates ext 5, ext 4, serial 4 tx/rx, serial 3 tx/rx
  // - upper enable bit 1 gates ext 7, bit 0 ext 6; bits 5..2 control nothing
  // - group level is {high priority bit, low priority bit}; 11 highest, 00 lowest
  // - a configured pin trigger sets that pin's pending flag
  // - writing 0 to a pending bit clears it
  // - trigger type bit selects level (0, reset) or edge (1) sensing
  // - level mode: sense 0 fires while pin high, sense 1 while low
  // - edge mode: sense 0 fires on rising edge, sense 1 on falling
  // - dual-edge bit fires on both edges, overriding type and sense
  // - pin enable bit 1 allows detection, 0 blocks it; resets to 0
  // - global gate at 0 blocks every core request regardless of enables; the irq output does not depend on it
  // - 32 sources in 8 groups of 4; lower number wins among equals
  // - pending flag clears when the core acknowledges that interrupt

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_ENABLE = 8'hA3;
  localparam logic [7:0] IDX_PENDING = 8'hA4;
  localparam logic [7:0] IDX_TRIGGER_TYPE = 8'hA5;
  localparam logic [7:0] IDX_SENSE = 8'hA6;
  localparam logic [7:0] IDX_DUAL_EDGE = 8'hA7;
  localparam logic [7:0] IDX_TIMER_EN = 8'hAA;
  localparam logic [7:0] IDX_MISC_EN = 8'hAB;
  localparam logic [7:0] IDX_SERIAL_EXT_EN = 8'hAC;
  localparam logic [7:0] IDX_UPPER_EXT_EN = 8'hAD;
  localparam logic [7:0] IDX_PRIO_LOW = 8'hB8;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hF8;
  localparam logic [7:0] IDX_GLOBAL_CTRL = 8'hC0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hC2;
  localparam logic [7:0] IDX_LOW_SRC_EN = 8'hC3;
  localparam logic [7:0] IDX_REQ_STATE = 8'hC4;

  // reset values and field positions
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_FIELD6 = 6'h00;
  localparam logic [11:0] RST_LOW_SRC = 12'h000;
  localparam int GLOBAL_GATE_BIT = 0;
  localparam int NUM_SRC = 32;
  localparam int GROUP_SIZE = 4;
  localparam int NUM_PIN = 8;
  localparam int SRC_FIELD_W = 6;
  localparam int LOW_SRC_W = 12;
  localparam int UPPER_USED = 2;
  localparam int TIMER_BASE = 12;
  localparam int MISC_BASE = 18;
  localparam int SERIAL_BASE = 24;
  localparam int UPPER_BASE = 30;

  // source number of each external pin
  localparam logic [4:0] EXT_SRC_ID [NUM_PIN] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1C, 5'h1D, 5'h1E, 5'h1F};

  typedef struct packed {
    logic valid;
    logic [4:0] id;
    logic [1:0] level;
  } req_s;

  typedef struct packed {
    logic valid;
    logic [4:0] id;
  } ack_s;
endpackage

// ===== logic/irq_enable_priority_extint.sv
// Added by the designer: the APB register port.
module irq_enable_priority_extint
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] srcReq,
  input wire logic [NUM_PIN-1:0] extPin,
  input wire ack_s coreAck,
  output req_s coreReq,
  output logic irq
);

  logic [7:0] pinEnable_reg, pending_reg, trigType_reg, sense_reg, dualEdge_reg;
  logic [7:0] prioLow_reg, prioHigh_reg, irqStatus_reg, irqMask_reg;
  logic [5:0] timerEn_reg, miscEn_reg, serialEn_reg, upperEn_reg;
  logic [11:0] lowEn_reg;
  logic gate_reg;
  logic [7:0] pinCur_reg, pinPrev_reg;
  logic [7:0] pending_next, irqStatus_next;
  logic [7:0] trigVec, riseVec, fallVec, ackClr;
  logic [NUM_SRC-1:0] enVec, reqVec, gatedReq;
  logic [7:0] idx;
  logic setup, access, wrEn, rdEn, hit;
  logic [31:0] readMux;
  logic bestValid;
  logic [4:0] bestId;
  logic [1:0] bestLevel;

  // bus phase decode
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wrEn = access & pwrite & hit;
  assign rdEn = access & ~pwrite & hit;

  // read data mux and address hit
  always_comb begin
    hit = (paddr[11:10] == 2'h0);
    readMux = 32'h0000_0000;
    case (idx)
      IDX_PIN_ENABLE: readMux[7:0] = pinEnable_reg;
      IDX_PENDING: readMux[7:0] = pending_reg;
      IDX_TRIGGER_TYPE: readMux[7:0] = trigType_reg;
      IDX_SENSE: readMux[7:0] = sense_reg;
      IDX_DUAL_EDGE: readMux[7:0] = dualEdge_reg;
      IDX_TIMER_EN: readMux[5:0] = timerEn_reg;
      IDX_MISC_EN: readMux[5:0] = miscEn_reg;
      IDX_SERIAL_EXT_EN: readMux[5:0] = serialEn_reg;
      IDX_UPPER_EXT_EN: readMux[5:0] = upperEn_reg;
      IDX_PRIO_LOW: readMux[7:0] = prioLow_reg;
      IDX_PRIO_HIGH: readMux[7:0] = prioHigh_reg;
      IDX_GLOBAL_CTRL: readMux[GLOBAL_GATE_BIT] = gate_reg;
      IDX_IRQ_STATUS: readMux[7:0] = irqStatus_reg;
      IDX_IRQ_MASK: readMux[7:0] = irqMask_reg;
      IDX_LOW_SRC_EN: readMux[11:0] = lowEn_reg;
      IDX_REQ_STATE: readMux[7:0] = coreReq;
      default: hit = 1'b0;
    endcase
  end

  // apb answer: one wait-free access phase after each setup
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup & ~pwrite & hit) ? readMux : 32'h0000_0000;
      pslverr <= setup & ~hit;
    end
  end

  // configuration registers written by software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinEnable_reg <= RST_BYTE;
      trigType_reg <= RST_BYTE;
      sense_reg <= RST_BYTE;
      dualEdge_reg <= RST_BYTE;
      prioLow_reg <= RST_BYTE;
      prioHigh_reg <= RST_BYTE;
      irqMask_reg <= RST_BYTE;
      timerEn_reg <= RST_FIELD6;
      miscEn_reg <= RST_FIELD6;
      serialEn_reg <= RST_FIELD6;
      upperEn_reg <= RST_FIELD6;
      lowEn_reg <= RST_LOW_SRC;
      gate_reg <= 1'b0;
    end else if (wrEn) begin
      case (idx)
        IDX_PIN_ENABLE: pinEnable_reg <= pwdata[7:0];
        IDX_TRIGGER_TYPE: trigType_reg <= pwdata[7:0];
        IDX_SENSE: sense_reg <= pwdata[7:0];
        IDX_DUAL_EDGE: dualEdge_reg <= pwdata[7:0];
        IDX_PRIO_LOW: prioLow_reg <= pwdata[7:0];
        IDX_PRIO_HIGH: prioHigh_reg <= pwdata[7:0];
        IDX_IRQ_MASK: irqMask_reg <= pwdata[7:0];
        IDX_TIMER_EN: timerEn_reg <= pwdata[5:0];
        IDX_MISC_EN: miscEn_reg <= pwdata[5:0];
        IDX_SERIAL_EXT_EN: serialEn_reg <= pwdata[5:0];
        IDX_UPPER_EXT_EN: upperEn_reg <= pwdata[5:0];
        IDX_LOW_SRC_EN: lowEn_reg <= pwdata[11:0];
        IDX_GLOBAL_CTRL: gate_reg <= pwdata[GLOBAL_GATE_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinCur_reg <= RST_BYTE;
      pinPrev_reg <= RST_BYTE;
    end else begin
      pinCur_reg <= extPin;
      pinPrev_reg <= pinCur_reg;
    end
  end

  // per-pin trigger detection
  for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
    logic levelHit, edgeHit;
    assign riseVec[p] = pinCur_reg[p] & ~pinPrev_reg[p];
    assign fallVec[p] = ~pinCur_reg[p] & pinPrev_reg[p];
    assign levelHit = sense_reg[p] ? ~pinCur_reg[p] : pinCur_reg[p];
    assign edgeHit = sense_reg[p] ? fallVec[p] : riseVec[p];
    assign trigVec[p] = pinEnable_reg[p] &
                        (dualEdge_reg[p] ? (riseVec[p] | fallVec[p]) : (trigType_reg[p] ? edgeHit : levelHit));
    assign ackClr[p] = coreAck.valid & (coreAck.id == EXT_SRC_ID[p]);
  end

  // pending flags: trigger wins over any clear in the same cycle
  always_comb begin
    pending_next = pending_reg;
    if (wrEn && idx == IDX_PENDING) begin
      pending_next = pwdata[7:0];
    end
    pending_next = pending_next & ~ackClr;
    pending_next = pending_next | trigVec;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= RST_BYTE;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // sticky event status, cleared by read, set wins
  always_comb begin
    irqStatus_next = irqStatus_reg;
    if (rdEn && idx == IDX_IRQ_STATUS) begin
      irqStatus_next = irqStatus_reg & ~prdata[7:0]; // only bits returned, later events survive
    end
    irqStatus_next = irqStatus_next | trigVec;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStatus_reg <= RST_BYTE;
      irq <= 1'b0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  assign enVec = {upperEn_reg[UPPER_USED-1:0], serialEn_reg, miscEn_reg, timerEn_reg, lowEn_reg};

  // request vector with external sources taken from pending flags
  always_comb begin
    reqVec = srcReq;
    for (int p = 0; p < NUM_PIN; p++) begin
      reqVec[EXT_SRC_ID[p]] = pending_reg[p];
    end
  end

  assign gatedReq = gate_reg ? (reqVec & enVec) : '0;

  function automatic logic [1:0] srcLevel(input int s, input logic [7:0] hi, input logic [7:0] lo);
    return {hi[s / GROUP_SIZE], lo[s / GROUP_SIZE]};
  endfunction

  // highest level wins, lower number among equals
  always_comb begin
    bestValid = 1'b0;
    bestId = 5'h00;
    bestLevel = 2'h0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (gatedReq[s] && (!bestValid || srcLevel(s, prioHigh_reg, prioLow_reg) > bestLevel)) begin
        bestValid = 1'b1;
        bestId = 5'(s);
        bestLevel = srcLevel(s, prioHigh_reg, prioLow_reg);
      end
    end
  end

  // request to the core
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      coreReq <= '0;
    end else begin
      coreReq.valid <= bestValid;
      coreReq.id <= bestId;
      coreReq.level <= bestLevel;
    end
  end

  // helper logic for checks
  logic [NUM_SRC-1:0] gatedPrev_reg;
  logic [7:0] prioLowPrev_reg, prioHighPrev_reg;
  logic [NUM_SRC-1:0] beatVec;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gatedPrev_reg <= '0;
      prioLowPrev_reg <= RST_BYTE;
      prioHighPrev_reg <= RST_BYTE;
    end else begin
      gatedPrev_reg <= gatedReq;
      prioLowPrev_reg <= prioLow_reg;
      prioHighPrev_reg <= prioHigh_reg;
    end
  end

  always_comb begin
    beatVec = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      beatVec[s] = gatedPrev_reg[s] &&
                   (srcLevel(s, prioHighPrev_reg, prioLowPrev_reg) > coreReq.level ||
                    (srcLevel(s, prioHighPrev_reg, prioLowPrev_reg) == coreReq.level && 5'(s) < coreReq.id));
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_timerGate;
    coreReq.valid && coreReq.id >= 5'd12 && coreReq.id <= 5'd17
      |-> (($past(timerEn_reg) >> (coreReq.id - 5'd12)) & 6'h01) != 6'h00;
  endproperty
  a_timerGate: assert property (p_timerGate) else $error("timer request passed while disabled");

  property p_miscGate;
    coreReq.valid && coreReq.id >= 5'd18 && coreReq.id <= 5'd23
      |-> (($past(miscEn_reg) >> (coreReq.id - 5'd18)) & 6'h01) != 6'h00;
  endproperty
  a_miscGate: assert property (p_miscGate) else $error("misc request passed while disabled");

  property p_serialGate;
    coreReq.valid && coreReq.id >= 5'd24 && coreReq.id <= 5'd29
      |-> (($past(serialEn_reg) >> (coreReq.id - 5'd24)) & 6'h01) != 6'h00;
  endproperty
  a_serialGate: assert property (p_serialGate) else $error("serial or ext request passed while disabled");

  property p_upperGate;
    coreReq.valid && coreReq.id >= 5'd30 |-> (($past(upperEn_reg) >> (coreReq.id - 5'd30)) & 6'h01) != 6'h00;
  endproperty
  a_upperGate: assert property (p_upperGate) else $error("ext 6 or 7 request passed while disabled");

  property p_level;
    coreReq.valid |-> coreReq.level == {prioHighPrev_reg[coreReq.id[4:2]], prioLowPrev_reg[coreReq.id[4:2]]};
  endproperty
  a_level: assert property (p_level) else $error("request level does not match group priority");

  property p_trigSets;
    (|trigVec) |=> ((pending_reg & $past(trigVec)) == $past(trigVec));
  endproperty
  a_trigSets: assert property (p_trigSets) else $error("trigger did not set pending flag");

  property p_writeClear;
    wrEn && idx == IDX_PENDING |=> (pending_reg & ~$past(pwdata[7:0]) & ~$past(trigVec)) == 8'h00;
  endproperty
  a_writeClear: assert property (p_writeClear) else $error("written zero did not clear pending");

  property p_levelHigh;
    pinEnable_reg[6] && !dualEdge_reg[6] && !trigType_reg[6] && !sense_reg[6] && pinCur_reg[6] |=> pending_reg[6];
  endproperty
  a_levelHigh: assert property (p_levelHigh) else $error("high level did not set pending");

  property p_fallEdge;
    pinEnable_reg[1] && !dualEdge_reg[1] && trigType_reg[1] && !sense_reg[1] && fallVec[1] && !pending_reg[1]
      && !wrEn |=> !pending_reg[1];
  endproperty
  a_fallEdge: assert property (p_fallEdge) else $error("falling edge fired in rising mode");

  property p_dualEdge;
    pinEnable_reg[5] && dualEdge_reg[5] && fallVec[5] |=> pending_reg[5];
  endproperty
  a_dualEdge: assert property (p_dualEdge) else $error("dual edge missed a falling edge");

  property p_pinDisabled;
    !pinEnable_reg[3] && !pending_reg[3] && !wrEn |=> !pending_reg[3];
  endproperty
  a_pinDisabled: assert property (p_pinDisabled) else $error("disabled pin set pending");

  property p_globalGate;
    !gate_reg |=> !coreReq.valid;
  endproperty
  a_globalGate: assert property (p_globalGate) else $error("request passed with global gate off");

  property p_order;
    coreReq.valid |-> beatVec == '0;
  endproperty
  a_order: assert property (p_order) else $error("a better source was passed over");

  property p_ackClear;
    coreAck.valid && coreAck.id == 5'd28 && !trigVec[4] |=> !pending_reg[4];
  endproperty
  a_ackClear: assert property (p_ackClear) else $error("acknowledge did not clear ext 4 pending");

  c_extReq: cover property (pending_reg[6] ##1 coreReq.valid && coreReq.id == 5'd30);
  c_preempt: cover property (coreReq.valid && coreReq.level == 2'h3 && coreReq.id > 5'd0);
  c_statusRead: cover property (rdEn && idx == IDX_IRQ_STATUS && irq);

endmodule

// ===== dv/core_partner.sv
// processor core stand-in: acknowledges the offered request after a programmable wait
module core_partner
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire req_s coreReq,
  input wire logic ackOn,
  input wire logic [3:0] ackDelay,
  output ack_s coreAck
);
  logic [3:0] waitCnt;

  // service entry pulse, one cycle wide, then wait again so a stale request is not re-acked at once
  // service entry ack
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      coreAck <= '0;
      waitCnt <= 4'h0;
    end else begin
      coreAck <= '0;
      if (ackOn && coreReq.valid && !coreAck.valid) begin
        if (waitCnt >= ackDelay) begin
          coreAck.valid <= 1'h1;
          coreAck.id <= coreReq.id;
          waitCnt <= 4'h0;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end else begin
        waitCnt <= 4'h0;
      end
    end
  end
endmodule

// ===== dv/tb_irq_enable_priority_extint.sv
module tb_irq_enable_priority_extint
  import irq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, irq, er, ackOn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [NUM_SRC-1:0] srcReq = '0;
  logic [NUM_PIN-1:0] extPin = '0;
  ack_s coreAck;
  req_s coreReq;
  int err_total = 0, samples_checked = 0, cyc = 0;

  irq_enable_priority_extint irq_enable_priority_extint_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .srcReq(srcReq), .extPin(extPin), .coreAck(coreAck), .coreReq(coreReq), .irq(irq));
  core_partner core_partner_i (.ref_clk(ref_clk), .rst(rst), .coreReq(coreReq), .ackOn(ackOn),
    .ackDelay(4'h3), .coreAck(coreAck));

  // clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("CHECK FAILED at %0t: timeout got %h exp %h", $time, cyc, 0);
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
    apb(1'h0, idx, 32'h0);
    chk(rd, e);
  endtask

  task automatic expReq(input logic v, input logic [4:0] id, input logic [1:0] lv);
    repeat (3) @(posedge ref_clk);
    chk({24'h0, coreReq}, {24'h0, v, id, lv});
  endtask

  // reset values, access widths, unmapped index
  task automatic t_regs();
    logic [7:0] idx [10] = '{IDX_TIMER_EN, IDX_MISC_EN, IDX_SERIAL_EXT_EN, IDX_UPPER_EXT_EN, IDX_PRIO_LOW,
      IDX_PRIO_HIGH, IDX_TRIGGER_TYPE, IDX_SENSE, IDX_DUAL_EDGE, IDX_PIN_ENABLE};
    for (int i = 0; i < 10; i++) begin
      rdchk(idx[i], 32'h0);
      apb(1'h1, idx[i], 32'hFFFFFFFF);
      rdchk(idx[i], (i < 4) ? 32'h3F : 32'hFF);
      apb(1'h1, idx[i], 32'h0);
    end
    rdchk(IDX_PENDING, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask

  // each peripheral enable bit passes and blocks its own source
  task automatic t_gates();
    logic [7:0] r;
    apb(1'h1, IDX_GLOBAL_CTRL, 32'h1);
    for (int s = TIMER_BASE; s < 28; s++) begin
      r = (s < MISC_BASE) ? IDX_TIMER_EN : (s < SERIAL_BASE) ? IDX_MISC_EN : IDX_SERIAL_EXT_EN;
      srcReq <= 32'h1 << s;
      apb(1'h1, r, 32'h1 << ((s - TIMER_BASE) % 6));
      expReq(1'h1, 5'(s), 2'h0);
      apb(1'h1, r, 32'h0);
      expReq(1'h0, 5'h00, 2'h0);
    end
  endtask

  // group levels, ties and the global gate
  task automatic t_prio();
    srcReq <= (32'h1 << 12) | (32'h1 << 17);
    apb(1'h1, IDX_TIMER_EN, 32'h21);
    expReq(1'h1, 5'h0C, 2'h0);
    apb(1'h1, IDX_PRIO_HIGH, 32'h10);
    expReq(1'h1, 5'h11, 2'h2);
    apb(1'h1, IDX_PRIO_LOW, 32'h08);
    expReq(1'h1, 5'h11, 2'h2);
    apb(1'h1, IDX_PRIO_HIGH, 32'h18);
    expReq(1'h1, 5'h0C, 2'h3);
    apb(1'h1, IDX_PRIO_LOW, 32'h18);
    expReq(1'h1, 5'h0C, 2'h3);
    rdchk(IDX_REQ_STATE, {24'h0, 1'h1, 5'h0C, 2'h3});
    apb(1'h1, IDX_GLOBAL_CTRL, 32'h0);
    expReq(1'h0, 5'h00, 2'h0);
    srcReq <= '0;
    apb(1'h1, IDX_TIMER_EN, 32'h0);
    apb(1'h1, IDX_GLOBAL_CTRL, 32'h1);
  endtask

  // configure one pin, clear its flag, move the pin from a to b, expect flag x
  task automatic extTrig(input int p, input logic ty, se, bo, en, a, b, x);
    extPin[p] <= a;
    apb(1'h1, IDX_PIN_ENABLE, 32'(en) << p);
    apb(1'h1, IDX_TRIGGER_TYPE, 32'(ty) << p);
    apb(1'h1, IDX_SENSE, 32'(se) << p);
    apb(1'h1, IDX_DUAL_EDGE, 32'(bo) << p);
    apb(1'h1, IDX_PENDING, 32'h0);
    extPin[p] <= b;
    repeat (4) @(posedge ref_clk);
    rdchk(IDX_PENDING, 32'(x) << p);
    extPin[p] <= 1'h0;
    apb(1'h1, IDX_PIN_ENABLE, 32'h0);
  endtask

  task automatic t_ext();
    extTrig(0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    extTrig(1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    extTrig(2, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    extTrig(3, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    extTrig(5, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
    extTrig(6, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    extTrig(7, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
    extTrig(4, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
    extTrig(4, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
  endtask

  // pin event to core request, status and mask, then service entry clears the flag
  task automatic t_irq();
    apb(1'h0, IDX_IRQ_STATUS, 32'h0);
    apb(1'h1, IDX_SERIAL_EXT_EN, 32'h10);
    extTrig(4, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    expReq(1'h1, 5'h1C, 2'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, IDX_IRQ_MASK, 32'h10);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    rdchk(IDX_IRQ_STATUS, 32'h10);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    ackOn <= 1'h1;
    repeat (10) @(posedge ref_clk);
    ackOn <= 1'h0;
    rdchk(IDX_PENDING, 32'h0);
    expReq(1'h0, 5'h00, 2'h0);
  endtask

  // reserved upper enable bits gate nothing, bit 0 passes ext 6
  task automatic t_upper();
    apb(1'h1, IDX_UPPER_EXT_EN, 32'h3C);
    extTrig(6, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    expReq(1'h0, 5'h00, 2'h0);
    apb(1'h1, IDX_UPPER_EXT_EN, 32'h01);
    expReq(1'h1, 5'h1E, 2'h0);
    apb(1'h1, IDX_PENDING, 32'h0);
    apb(1'h1, IDX_UPPER_EXT_EN, 32'h0);
    expReq(1'h0, 5'h00, 2'h0);
  endtask

  // reset, scenarios, verdict
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    t_regs();
    t_gates();
    t_prio();
    t_ext();
    t_irq();
    t_upper();
    finish_test();
  end
endmodule
